// ===== wiper_nvm_store_restore_timing_tb.sv
// self-checking bench for the wiper nvm controller
`timescale 1ns/1ps
module wiper_nvm_store_restore_timing_tb;
	import wnv_pkg::*;
	localparam int L = 8;
	localparam int S = 20;
	localparam int RW = 30;
	logic       clock, rst, scl_pin, scl_rise, sda_pull, sda_out, sda_oe, sda_sampled;
	logic       busy, rewrite_ok, go, m_low;
	logic [7:0] tx;
	logic [5:0] wiper;
	logic [6:0] slave_addr;
	wire logic  sda_in;
	wnv_tri_t   a0, a1;
	wnv_cmd_t   cmd;
	int         bad_count, samples_checked, cnt, n;
	// open drain line with pull-up: either party may pull it low
	assign sda_in = ~(m_low | (sda_oe & ~sda_out));
	wnv_master model_u (.go(go), .tx(tx), .scl(scl_pin), .sda_low(m_low));
	wnv_ctrl #(.LOAD_CYC(L), .STORE_CYC(S), .REWRITE_CYC(RW)) dut_u (
		.clock(clock), .rst(rst), .addr_select_pin0(a0), .addr_select_pin1(a1),
		.scl_pin(scl_pin), .scl_rise(scl_rise), .sda_in(sda_in), .sda_pull(sda_pull),
		.sda_out(sda_out), .sda_oe(sda_oe), .cmd(cmd), .wiper(wiper),
		.slave_addr(slave_addr), .busy(busy), .rewrite_ok(rewrite_ok),
		.sda_sampled(sda_sampled));
	// clock and a cycle count since reset release
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) cnt <= rst ? 0 : cnt + 1;
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc
	// bounded wait for busy to drop; n holds the cycles it stayed high
	task automatic wait_busy;
		n = 0;
		while (busy !== 1'b0) begin
			n++;
			if (n > S + 20) begin
				chk("busy timeout", 8'h00, 8'h01);
				end_of_test();
			end
			cyc(1);
		end
	endtask : wait_busy
	task automatic issue(input wnv_cmd_t c);
		cmd = c;
		cyc(1);
		cmd = '0;
		cyc(1);
	endtask : issue
	// preset, power-up load, address latch
	task automatic t_power;
		chk("wiper in reset", 8'h20, wiper);
		cyc(2);
		rst = 1'b0;
		cyc(1);
		chk("wiper preset", 8'h20, wiper);
		wait_busy();
		chk("load time", 8'h01, n >= L - 2 && n <= L);
		chk("erased wiper", 8'h20, wiper);
		chk("slave addr", 8'h1d, slave_addr);
		a0 = WNV_PIN_LOW;
		a1 = WNV_PIN_LOW;
		cyc(6);
		chk("addr held", 8'h1d, slave_addr);
	endtask : t_power
	// store refused before the settling interval
	task automatic t_early;
		chk("rewrite early", 8'h00, rewrite_ok);
		issue('{store: 1'b1, default: '0});
		chk("early store", 8'h00, busy);
		while (rewrite_ok !== 1'b1 && cnt < RW + 5)
			cyc(1);
		chk("rewrite time", 8'h01, cnt >= RW - 1 && cnt <= RW + 2);
		if (rewrite_ok !== 1'b1)
			end_of_test();
	endtask : t_early
	// write, store with a restore attempt mid-store, overwrite, restore
	task automatic t_nvm;
		issue('{write: 1'b1, data: 6'h2a, default: '0});
		cyc(2);
		chk("written", 8'h2a, wiper);
		issue('{store: 1'b1, default: '0});
		chk("store busy", 8'h01, busy);
		issue('{restore: 1'b1, default: '0});
		wait_busy();
		chk("store time", 8'h01, n >= S - 5 && n <= S);
		cyc(1);
		chk("no queued op", 8'h00, busy);
		issue('{write: 1'b1, data: 6'h05, default: '0});
		cyc(2);
		chk("overwrite", 8'h05, wiper);
		issue('{restore: 1'b1, default: '0});
		chk("restore busy", 8'h01, busy);
		wait_busy();
		chk("restore time", 8'h01, n >= L - 2 && n <= L);
		chk("restored", 8'h2a, wiper);
	endtask : t_nvm
	// one byte on the serial pins, then the device pulls the data line
	task automatic t_serial;
		int k;
		tx = 8'ha5;
		go = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			k = 0;
			while (scl_rise !== 1'b1) begin
				k++;
				if (k > 20) begin
					chk("scl_rise timeout", 8'h01, 8'h00);
					end_of_test();
				end
				cyc(1);
			end
			cyc(1);
			chk("sampled bit", {7'h00, tx[i]}, {7'h00, sda_sampled});
		end
		go = 1'b0;
		sda_pull = 1'b1;
		cyc(2);
		chk("pulls low", 8'h10, {3'h0, sda_oe, 3'h0, sda_in});
		sda_pull = 1'b0;
	endtask : t_serial
	initial begin
		rst = 1'b1;
		cmd = '0;
		sda_pull = 1'b0;
		go = 1'b0;
		tx = 8'h00;
		a0 = WNV_PIN_FLOAT;
		a1 = WNV_PIN_HIGH;
		cyc(2);
		t_power();
		t_early();
		t_nvm();
		t_serial();
		end_of_test();
	end
endmodule : wiper_nvm_store_restore_timing_tb

// ===== wnv_ctrl.sv
// wiper nvm power-up, store/restore timing and address latching
`timescale 1ns/1ps
`include "wnv_regs.svh"
module wnv_ctrl #(
	parameter int LOAD_CYC    = `WNV_LOAD_CYC,
	parameter int STORE_CYC   = `WNV_STORE_CYC,
	parameter int REWRITE_CYC = `WNV_REWRITE_CYC
) (
	// clock and power-on reset
	input  wire logic                        clock,
	input  wire logic                        rst,
	// address pins, already resolved to three states
	input  wire wnv_pkg::wnv_tri_t           addr_select_pin0,
	input  wire wnv_pkg::wnv_tri_t           addr_select_pin1,
	// serial clock pin and sampled rising edge
	input  wire logic                        scl_pin,
	output logic                             scl_rise,
	// serial data pin, open drain
	input  wire logic                        sda_in,
	input  wire logic                        sda_pull,
	output logic                             sda_out,
	output logic                             sda_oe,
	// decoded command from the protocol layer
	input  wire wnv_pkg::wnv_cmd_t           cmd,
	// wiper and status
	output logic [`WNV_WIPER_W-1:0]          wiper,
	output logic [6:0]                       slave_addr,
	output logic                             busy,
	output logic                             rewrite_ok,
	output logic                             sda_sampled
);
	import wnv_pkg::*;

	wnv_state_t            state;
	logic [31:0]           cnt;
	logic [31:0]           rw_cnt;
	logic [`WNV_WIPER_W-1:0] nvm;
	logic                  nvm_prog;
	logic [1:0]            pins_s;
	logic [3:0]            ad_s;
	logic                  scl_d;
	logic                  latched;

	// pins pass two flops before any logic reads them
	wnv_sync #(.WIDTH(6)) u_sync (
		.clock (clock),
		.rst   (rst),
		.din   ({addr_select_pin1, addr_select_pin0, scl_pin, sda_in}),
		.dout  ({ad_s, pins_s})
	);

	// rising edge of serial clock from synchronised copy
	always_ff @(posedge clock) begin
		if (rst) begin
			scl_d    <= 1'b1; // matches the idle-high line, no edge after reset
			scl_rise <= 1'b0;
		end else begin
			scl_d    <= pins_s[1];
			scl_rise <= pins_s[1] & ~scl_d;
		end
	end

	// data line sampled on serial clock rise, driven low only
	always_ff @(posedge clock) begin
		if (rst) begin
			sda_sampled <= 1'b0;
			sda_out     <= 1'b0;
			sda_oe      <= 1'b0;
		end else begin
			if (pins_s[1] & ~scl_d)
				sda_sampled <= pins_s[0];
			sda_out <= 1'b0;
			sda_oe  <= sda_pull;
		end
	end

	// address pins caught once at the end of the power-up load, held until next power cycle
	// waiting for the load end lets the synchroniser fill with the real pin levels
	always_ff @(posedge clock) begin
		if (rst) begin
			latched    <= 1'b0;
			slave_addr <= `WNV_ADDR_BASE;
		end else if (!latched && state == WNV_PULOAD && cnt == 32'(LOAD_CYC - 1)) begin
			latched    <= 1'b1;
			// each pin gives one of three codes: base plus pin1*3 + pin0
			slave_addr <= `WNV_ADDR_BASE + 7'(ad_s[3:2]) * 7'h3 + 7'(ad_s[1:0]);
		end
	end

	// nvm contents; erased state reads as midscale
	always_ff @(posedge clock) begin
		if (rst) begin
			nvm_prog <= 1'b0;
			nvm      <= `WNV_MIDSCALE;
		end else if (state == WNV_STORE && cnt == 32'(STORE_CYC - 1)) begin
			nvm_prog <= 1'b1;
			nvm      <= wiper;
		end
	end

	// sequencer: preset, power-up load, then serve one nvm op at a time
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= WNV_PRESET;
			cnt   <= 32'h0;
			wiper <= `WNV_MIDSCALE;
			busy  <= 1'b1;
		end else begin
			case (state)
			WNV_PRESET: begin
				wiper <= `WNV_MIDSCALE;
				cnt   <= 32'h0;
				state <= WNV_PULOAD;
			end
			WNV_PULOAD: begin
				cnt <= cnt + 32'h1;
				if (cnt == 32'(LOAD_CYC - 1)) begin
					wiper <= nvm_prog ? nvm : `WNV_MIDSCALE;
					state <= WNV_IDLE;
					busy  <= 1'b0;
				end
			end
			WNV_IDLE: begin
				cnt <= 32'h0;
				if (cmd.store && rewrite_ok) begin
					state <= WNV_STORE;
					busy  <= 1'b1;
				end else if (cmd.restore) begin
					state <= WNV_RESTORE;
					busy  <= 1'b1;
				end else if (cmd.write) begin
					wiper <= cmd.data;
				end
			end
			WNV_RESTORE: begin
				cnt <= cnt + 32'h1;
				if (cnt == 32'(LOAD_CYC - 1)) begin
					wiper <= nvm;
					state <= WNV_IDLE;
					busy  <= 1'b0;
				end
			end
			WNV_STORE: begin
				cnt <= cnt + 32'h1;
				if (cnt == 32'(STORE_CYC - 1)) begin
					state <= WNV_IDLE;
					busy  <= 1'b0;
				end
			end
			default: begin
				state <= WNV_PRESET;
			end
			endcase
		end
	end

	// nvm writes held off for the rewrite interval after preset
	always_ff @(posedge clock) begin
		if (rst) begin
			rw_cnt     <= 32'h0;
			rewrite_ok <= 1'b0;
		end else if (!rewrite_ok) begin
			rw_cnt <= rw_cnt + 32'h1;
			if (rw_cnt == 32'(REWRITE_CYC - 1))
				rewrite_ok <= 1'b1;
		end
	end

	sequence preset_then_load_s;
		state == WNV_PRESET ##1 state == WNV_PULOAD;
	endsequence

	preset_first_a: assert property (@(posedge clock) disable iff (rst)
		preset_then_load_s |-> wiper == `WNV_MIDSCALE)
		else $error("wiper not midscale at load start");
	busy_op_a: assert property (@(posedge clock) disable iff (rst)
		(state == WNV_STORE || state == WNV_RESTORE) |-> busy)
		else $error("busy low during nvm op");
	no_early_store_a: assert property (@(posedge clock) disable iff (rst)
		(state == WNV_IDLE ##1 state == WNV_STORE) |-> $past(rewrite_ok))
		else $error("store before rewrite interval");
	restore_copy_a: assert property (@(posedge clock) disable iff (rst)
		(state == WNV_RESTORE && cnt == 32'(LOAD_CYC - 1)) |=> wiper == $past(nvm))
		else $error("restore did not copy nvm");
	store_copy_a: assert property (@(posedge clock) disable iff (rst)
		(state == WNV_STORE && cnt == 32'(STORE_CYC - 1)) |=> nvm == $past(wiper))
		else $error("store did not copy wiper");
	addr_hold_a: assert property (@(posedge clock) disable iff (rst)
		$past(latched) |-> $stable(slave_addr))
		else $error("slave address changed after latch");
	unprog_mid_a: assert property (@(posedge clock) disable iff (rst)
		!nvm_prog |-> nvm == `WNV_MIDSCALE)
		else $error("erased nvm not midscale");
	scl_edge_a: assert property (@(posedge clock) disable iff (rst)
		scl_rise |-> !$past(scl_rise))
		else $error("scl rise pulse longer than one cycle");
	sda_capture_a: assert property (@(posedge clock) disable iff (rst)
		scl_rise |-> sda_sampled == $past(pins_s[0]))
		else $error("data line not captured at scl rise");
	load_done_a: assert property (@(posedge clock) disable iff (rst)
		(state == WNV_PULOAD && cnt == 32'(LOAD_CYC - 1)) |=> state == WNV_IDLE && !busy)
		else $error("power-up load did not finish on time");
	addr_decode_a: assert property (@(posedge clock) disable iff (rst)
		latched |-> slave_addr >= `WNV_ADDR_BASE)
		else $error("slave address out of range");
endmodule : wnv_ctrl

// ===== wnv_master.sv
// bus master model: clocks one byte out on the serial pins
`timescale 1ns/1ps
module wnv_master (
	// request from the bench
	input  wire logic       go,
	input  wire logic [7:0] tx,
	// serial pins
	output logic            scl,
	output logic            sda_low
);
	// clock stands high between frames; data bits change while clock is low, the release after the last bit while clock is high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		forever begin
			@(posedge go);
			for (int i = 7; i >= 0; i--) begin
				scl = 1'b0;
				#200 sda_low = ~tx[i]; // msb first
				#200 scl = 1'b1;
				#400;
			end
			sda_low = 1'b0; // released, pull-up takes the line
		end
	end
endmodule : wnv_master

// ===== wnv_pkg.sv
// types shared by the wiper nvm controller
package wnv_pkg;
	typedef enum logic [1:0] {
		WNV_PIN_LOW   = 2'h0,
		WNV_PIN_HIGH  = 2'h1,
		WNV_PIN_FLOAT = 2'h2
	} wnv_tri_t;
	typedef struct packed {
		logic store;
		logic restore;
		logic write;
		logic [5:0] data;
	} wnv_cmd_t;
	typedef enum logic [4:0] {
		WNV_PRESET  = 5'h01,
		WNV_PULOAD  = 5'h02,
		WNV_IDLE    = 5'h04,
		WNV_RESTORE = 5'h08,
		WNV_STORE   = 5'h10
	} wnv_state_t;
endpackage : wnv_pkg

// ===== wnv_regs.svh
// timing counts, field widths and reset values for the wiper nvm controller
`ifndef WNV_REGS_SVH
`define WNV_REGS_SVH
`define WNV_CLK_MHZ        10
`define WNV_LOAD_US        300
`define WNV_STORE_MS       26
`define WNV_REWRITE_US     540
`define WNV_LOAD_CYC       (`WNV_LOAD_US * `WNV_CLK_MHZ)
`define WNV_STORE_CYC      (`WNV_STORE_MS * 1000 * `WNV_CLK_MHZ)
`define WNV_REWRITE_CYC    (`WNV_REWRITE_US * `WNV_CLK_MHZ)
`define WNV_WIPER_W        6
`define WNV_MIDSCALE       6'h20
`define WNV_ADDR_BASE      7'h18
`endif

// ===== wnv_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module wnv_sync #(
	parameter int WIDTH = 1
) (
	// clock
	input  wire logic             clock,
	input  wire logic             rst,
	// level in and out
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;
	// first stage feeds only the second
	// reset to ones: bus lines idle high, so no false edge right after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			meta <= '1;
			dout <= '1;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : wnv_sync
